// ==== inc/tape_ctl_pkg.sv ====
// Constants and types for the tape channel control port.
package tape_ctl_pkg;

  // ****************************************************************
  // Channel bit positions (channel bit 0 is the MSB of the word)
  // ****************************************************************
  localparam int W = 16;
  // Vector index of channel bit n is 15 - n.
  localparam int CH_BIT0 = 15;
  localparam int STB_START = 15;   // Channel bit 0.
  localparam int STB_TERM = 14;    // Channel bit 1.
  localparam int STB_IFUNC = 13;   // Channel bit 2.
  localparam int STB_CLEAR = 12;   // Channel bit 3.
  localparam int STB_CTRL = 11;    // Channel bit 4.
  localparam int STB_TABLE = 10;   // Channel bit 5.
  localparam int STB_CURADDR = 9;  // Channel bit 6.
  localparam int CODE_LSB = 0;     // Channel bits C..F.
  localparam int CODE_W = 4;
  localparam logic [3:0] CONNECT_CODE_0 = 4'hc;
  localparam logic [3:0] CONNECT_CODE_1 = 4'hd;

  // ****************************************************************
  // Control word fields
  // ****************************************************************
  localparam int ADDR_W = 15;
  localparam int PAGE_OFS_W = 11;
  localparam int PAGE_W = 4;
  localparam int TBL_HI_W = 7;
  localparam int TBL_HI_LSB = 8;   // Channel bits 7..1 are vector bits 14..8.
  localparam int CTRL_CODE_W = 12;
  localparam int CONNECT_FLAG = 13; // Channel bit 2.
  localparam int IF_W = 7;
  localparam int IF_CODED = 0;
  localparam int IF_WRITE = 1;
  localparam int IF_ODD_EVEN = 3;
  localparam int IF_NO_MEM = 4;
  localparam int IF_HALT_ERR = 5;
  localparam int IF_REVERSE = 6;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [14:0] ADDR_RESET = 15'h0000;
  localparam logic [6:0] IF_RESET = 7'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  typedef enum logic [2:0] {
    STB_IDLE = 3'h1,
    STB_HELD = 3'h2,
    STB_FIRE = 3'h4
  } strobe_state_t;

endpackage

// ==== rtl/addr_field.sv ====
// Ones complement address latch used for the address control words.
`timescale 1ns/100ps
module addr_field #(
  parameter int WIDTH = 15
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clr,
  // Load strobe and complemented data
  input wire logic load,
  input wire logic [WIDTH-1:0] data_n,
  // True-form value
  output logic [WIDTH-1:0] value
);
  logic [WIDTH-1:0] value_q;

  // The processor sends addresses inverted; storing true form keeps users simple.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      value_q <= '0;
    end else if (clr) begin
      value_q <= '0;
    end else if (load) begin
      value_q <= ~data_n;
    end
  end

  assign value = value_q;
endmodule

// ==== rtl/strobe_pulse.sv ====
// Set-then-clear detector for one strobe bit of the strobe channel.
`timescale 1ns/100ps
module strobe_pulse (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clr,
  // Strobe level and qualifier
  input wire logic level,
  input wire logic linked,
  // One-cycle pulse on the falling edge of the strobe
  output logic fire
);
  tape_ctl_pkg::strobe_state_t state_q;
  tape_ctl_pkg::strobe_state_t state_d;

  // A strobe only counts when it is both raised and dropped while linked.
  always_comb begin
    state_d = state_q;
    case (state_q)
      tape_ctl_pkg::STB_IDLE: begin
        if (linked && level) begin
          state_d = tape_ctl_pkg::STB_HELD;
        end
      end
      tape_ctl_pkg::STB_HELD: begin
        if (!linked) begin
          state_d = tape_ctl_pkg::STB_IDLE;
        end else if (!level) begin
          state_d = tape_ctl_pkg::STB_FIRE;
        end
      end
      tape_ctl_pkg::STB_FIRE: begin
        state_d = tape_ctl_pkg::STB_IDLE;
      end
      default: begin
        state_d = tape_ctl_pkg::STB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= tape_ctl_pkg::STB_IDLE;
    end else if (clr) begin
      state_q <= tape_ctl_pkg::STB_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign fire = (state_q == tape_ctl_pkg::STB_FIRE);
endmodule

// ==== rtl/tape_channel_control_port.sv ====
// Control port of the tape channel adapter: output channels 5 and 6, input channel 5.
`timescale 1ns/100ps
// Summary of operation
// - Channel 5 words latched only by class strobe.
// - Compare flag stops writes at terminating address.
// - Terminating word bits F..5 give page offset.
// - Bits 4..1 give next page number.
// - Terminating address sent complemented, device inverts.
// - Starting address complemented, first transfer location.
// - Table bits 7..1 form upper table address.
// - Function bit 0 set selects table conversion.
// - Function bit 0 clear selects binary mode.
// - Function bit 1 selects read or write.
// - Function bit 3 selects every other bank.
// - Function bit 4 suppresses memory, address advances.
// - Function bit 5 stops transfer on parity error.
// - Function bit 6 reverses read storage order.
// - Function settings hold until reloaded or cleared.
// - Strobe bits 0,1,2,5 pulse load words.
// - Strobe bit 4 pulse sends controller code.
// - Strobe bit 3 performs program clear.
// - Strobe bit 6 selects current address status.
// - Connect code C/D links this adapter only.
// - Connecting selects default status automatically.
module tape_channel_control_port (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Adapter number strap: 0 answers code C, 1 answers code D
  input wire logic adapter_sel,
  // Output channels from the station control processor
  input wire logic [15:0] ctl_word,
  input wire logic [15:0] strobe_word,
  // Input channel 5 toward the processor
  output logic [15:0] status_word,
  output logic linked,
  // Datapath status feeding input channel 5
  input wire logic [14:0] current_addr,
  input wire logic [15:0] default_status,
  // Transfer datapath controls
  output logic [14:0] start_addr,
  output logic [10:0] term_offset,
  output logic [3:0] next_page,
  output logic compare_on_write,
  output logic [14:0] table_addr,
  output logic xlate_en,
  output logic write_op,
  output logic binary_mode,
  output logic odd_even_banks,
  output logic mem_inhibit,
  output logic halt_on_error,
  output logic read_reverse,
  output logic reverse_assembly,
  output logic start_pulse,
  output logic program_clear,
  // Peripheral controller code port
  output logic [11:0] ctrl_code,
  output logic ctrl_is_connect,
  output logic ctrl_send
);

  // ****************************************************************
  // Connect decode and program clear
  // ****************************************************************
  wire [3:0] code_in = strobe_word[tape_ctl_pkg::CODE_LSB +: tape_ctl_pkg::CODE_W];
  wire [3:0] own_code = adapter_sel ? tape_ctl_pkg::CONNECT_CODE_1 : tape_ctl_pkg::CONNECT_CODE_0;
  wire link_w = (code_in == own_code);
  wire clear_w = link_w && strobe_word[tape_ctl_pkg::STB_CLEAR];

  logic [14:0] term_addr;
  logic cmp_q;
  logic [6:0] ifunc_q;
  logic [6:0] tbl_hi;
  logic [11:0] code_q;
  logic conn_q;
  logic send_q;
  logic start_q;
  logic [15:0] status_q;
  logic fire_start;
  logic fire_term;
  logic fire_ifunc;
  logic fire_ctrl;
  logic fire_table;

  // ****************************************************************
  // Strobe detectors
  // ****************************************************************
  strobe_pulse u_stb_start (
    .clk(clk), .sys_rst(sys_rst), .clr(clear_w),
    .level(strobe_word[tape_ctl_pkg::STB_START]), .linked(link_w), .fire(fire_start)
  );
  strobe_pulse u_stb_term (
    .clk(clk), .sys_rst(sys_rst), .clr(clear_w),
    .level(strobe_word[tape_ctl_pkg::STB_TERM]), .linked(link_w), .fire(fire_term)
  );
  strobe_pulse u_stb_ifunc (
    .clk(clk), .sys_rst(sys_rst), .clr(clear_w),
    .level(strobe_word[tape_ctl_pkg::STB_IFUNC]), .linked(link_w), .fire(fire_ifunc)
  );
  strobe_pulse u_stb_ctrl (
    .clk(clk), .sys_rst(sys_rst), .clr(clear_w),
    .level(strobe_word[tape_ctl_pkg::STB_CTRL]), .linked(link_w), .fire(fire_ctrl)
  );
  strobe_pulse u_stb_table (
    .clk(clk), .sys_rst(sys_rst), .clr(clear_w),
    .level(strobe_word[tape_ctl_pkg::STB_TABLE]), .linked(link_w), .fire(fire_table)
  );

  // ****************************************************************
  // Address latches
  // ****************************************************************
  // Starting address occupies channel bits 1..F.
  addr_field #(.WIDTH(15)) u_start (
    .clk(clk), .sys_rst(sys_rst), .clr(clear_w), .load(fire_start),
    .data_n(ctl_word[14:0]), .value(start_addr)
  );
  addr_field #(.WIDTH(15)) u_term (
    .clk(clk), .sys_rst(sys_rst), .clr(clear_w), .load(fire_term),
    .data_n(ctl_word[14:0]), .value(term_addr)
  );
  addr_field #(.WIDTH(7)) u_table (
    .clk(clk), .sys_rst(sys_rst), .clr(clear_w), .load(fire_table),
    .data_n(ctl_word[tape_ctl_pkg::TBL_HI_LSB +: tape_ctl_pkg::TBL_HI_W]), .value(tbl_hi)
  );

  assign term_offset = term_addr[10:0];
  assign next_page = term_addr[14:11];
  assign table_addr = {tbl_hi, 8'h00};

  // ****************************************************************
  // Compare flag, internal functions, controller code
  // ****************************************************************
  // The compare flag is a control bit and is taken in true form.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmp_q <= 1'b0;
    end else if (clear_w) begin
      cmp_q <= 1'b0;
    end else if (fire_term) begin
      cmp_q <= ctl_word[tape_ctl_pkg::CH_BIT0];
    end
  end

  // Function bit n sits on channel bit n, vector bit 15-n.
  wire [6:0] ifunc_w = {ctl_word[9], ctl_word[10], ctl_word[11], ctl_word[12],
                        ctl_word[13], ctl_word[14], ctl_word[15]};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ifunc_q <= tape_ctl_pkg::IF_RESET;
      start_q <= 1'b0;
    end else if (clear_w) begin
      ifunc_q <= tape_ctl_pkg::IF_RESET;
      start_q <= 1'b0;
    end else begin
      if (fire_ifunc) begin
        ifunc_q <= ifunc_w;
      end
      start_q <= fire_ifunc;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      code_q <= 12'h000;
      conn_q <= 1'b0;
      send_q <= 1'b0;
    end else if (clear_w) begin
      code_q <= 12'h000;
      conn_q <= 1'b0;
      send_q <= 1'b0;
    end else begin
      if (fire_ctrl) begin
        code_q <= ctl_word[11:0];
        conn_q <= ctl_word[tape_ctl_pkg::CONNECT_FLAG];
      end
      send_q <= fire_ctrl;
    end
  end

  wire coded_w = ifunc_q[tape_ctl_pkg::IF_CODED];
  wire write_w = ifunc_q[tape_ctl_pkg::IF_WRITE];
  assign xlate_en = coded_w;
  assign binary_mode = !coded_w;
  assign write_op = write_w;
  assign odd_even_banks = ifunc_q[tape_ctl_pkg::IF_ODD_EVEN];
  assign mem_inhibit = ifunc_q[tape_ctl_pkg::IF_NO_MEM];
  assign halt_on_error = ifunc_q[tape_ctl_pkg::IF_HALT_ERR];
  assign read_reverse = ifunc_q[tape_ctl_pkg::IF_REVERSE] && !write_w;
  assign reverse_assembly = read_reverse && !coded_w;
  assign compare_on_write = cmp_q && write_w;
  assign start_pulse = start_q;
  assign ctrl_code = code_q;
  assign ctrl_is_connect = conn_q;
  assign ctrl_send = send_q;
  assign program_clear = clear_w;
  assign linked = link_w;

  // ****************************************************************
  // Input channel 5
  // ****************************************************************
  // Select is a level: a freshly connected processor with bit 6 clear sees
  // default status, so no separate select state is needed.
  wire cur_sel = link_w && strobe_word[tape_ctl_pkg::STB_CURADDR];
  wire [15:0] status_w = !link_w ? tape_ctl_pkg::WORD_RESET :
                         cur_sel ? {1'b0, current_addr} : default_status;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_q <= tape_ctl_pkg::WORD_RESET;
    end else begin
      status_q <= status_w;
    end
  end
  assign status_word = status_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Function word rebuilt from the channel bit order, independent of ifunc_w.
  logic [6:0] fn_chk;
  always_comb begin
    for (int n = 0; n < tape_ctl_pkg::IF_W; n++) begin
      fn_chk[n] = ctl_word[tape_ctl_pkg::CH_BIT0 - n];
    end
  end

  // A clear on either step cancels the strobe, so it is excluded here.
  sequence strobe_drop(int b);
    link_w && strobe_word[b] && !clear_w ##1 link_w && !strobe_word[b] && !clear_w;
  endsequence

  AST_TERM_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
    strobe_drop(tape_ctl_pkg::STB_TERM) ##1 !clear_w |=> term_addr == ~$past(ctl_word[14:0]))
    else $error("terminating address not complemented on load");
  AST_START_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
    strobe_drop(tape_ctl_pkg::STB_START) ##1 !clear_w |=> start_addr == ~$past(ctl_word[14:0]))
    else $error("starting address not loaded");
  AST_HOLD_START: assert property (@(posedge clk) disable iff (sys_rst)
    !fire_start && !clear_w |=> $stable(start_addr))
    else $error("starting address changed without strobe");
  AST_UNLINKED: assert property (@(posedge clk) disable iff (sys_rst)
    !link_w[*2] |=> !fire_start && !fire_term && !fire_ifunc && !fire_ctrl && !fire_table)
    else $error("strobe accepted while unlinked");
  AST_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    clear_w |=> ifunc_q == tape_ctl_pkg::IF_RESET && start_addr == 15'h0000)
    else $error("program clear did not reset adapter");
  AST_IFUNC_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    !fire_ifunc && !clear_w |=> $stable(ifunc_q))
    else $error("function bits changed without strobe");
  AST_CTRL_SEND: assert property (@(posedge clk) disable iff (sys_rst)
    fire_ctrl && !clear_w |=> ctrl_send && ctrl_code == $past(ctl_word[11:0]))
    else $error("controller code not sent");
  AST_CUR_SEL: assert property (@(posedge clk) disable iff (sys_rst)
    cur_sel |=> status_word == {1'b0, $past(current_addr)})
    else $error("current address not returned");
  AST_DEFAULT: assert property (@(posedge clk) disable iff (sys_rst)
    link_w && !cur_sel |=> status_word == $past(default_status))
    else $error("default status not returned");
  AST_MODE: assert property (@(posedge clk) disable iff (sys_rst)
    fire_ifunc && !clear_w |=> binary_mode == !$past(fn_chk[tape_ctl_pkg::IF_CODED]))
    else $error("binary mode not taken from function bit 0");
  AST_CODED: assert property (@(posedge clk) disable iff (sys_rst)
    fire_ifunc && !clear_w |=> xlate_en == $past(fn_chk[tape_ctl_pkg::IF_CODED]))
    else $error("code conversion not taken from function bit 0");
  AST_CMP_FLAG: assert property (@(posedge clk) disable iff (sys_rst)
    fire_term && !clear_w |=>
      compare_on_write == ($past(ctl_word[tape_ctl_pkg::CH_BIT0]) && write_op))
    else $error("compare flag not applied to writes");
  AST_OFFSET: assert property (@(posedge clk) disable iff (sys_rst)
    fire_term && !clear_w |=> term_offset == ~$past(ctl_word[tape_ctl_pkg::PAGE_OFS_W-1:0]))
    else $error("terminating page offset wrong");
  AST_PAGE: assert property (@(posedge clk) disable iff (sys_rst)
    fire_term && !clear_w |=>
      next_page == ~$past(ctl_word[tape_ctl_pkg::PAGE_OFS_W +: tape_ctl_pkg::PAGE_W]))
    else $error("next page number wrong");
  AST_TABLE_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
    fire_table && !clear_w |=>
      table_addr == {~$past(ctl_word[tape_ctl_pkg::TBL_HI_LSB +: tape_ctl_pkg::TBL_HI_W]), 8'h00})
    else $error("table address not loaded");
  AST_DIRECTION: assert property (@(posedge clk) disable iff (sys_rst)
    fire_ifunc && !clear_w |=> write_op == $past(fn_chk[tape_ctl_pkg::IF_WRITE]))
    else $error("direction not taken from function bit 1");
  AST_START_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
    fire_ifunc && !clear_w |=> start_pulse)
    else $error("function word did not start a transfer");
  AST_BANKS: assert property (@(posedge clk) disable iff (sys_rst)
    fire_ifunc && !clear_w |=> odd_even_banks == $past(fn_chk[tape_ctl_pkg::IF_ODD_EVEN]))
    else $error("bank select not taken from function bit 3");
  AST_NO_MEM: assert property (@(posedge clk) disable iff (sys_rst)
    fire_ifunc && !clear_w |=> mem_inhibit == $past(fn_chk[tape_ctl_pkg::IF_NO_MEM]))
    else $error("memory inhibit not taken from function bit 4");
  AST_HALT: assert property (@(posedge clk) disable iff (sys_rst)
    fire_ifunc && !clear_w |=> halt_on_error == $past(fn_chk[tape_ctl_pkg::IF_HALT_ERR]))
    else $error("halt on error not taken from function bit 5");
  AST_REVERSE: assert property (@(posedge clk) disable iff (sys_rst)
    fire_ifunc && !clear_w |=>
      read_reverse == ($past(fn_chk[tape_ctl_pkg::IF_REVERSE]) && !write_op))
    else $error("reverse storage not limited to reads");
  AST_ASSEMBLY: assert property (@(posedge clk) disable iff (sys_rst)
    fire_ifunc && !clear_w |=>
      reverse_assembly == ($past(fn_chk[tape_ctl_pkg::IF_REVERSE]) && !write_op && !xlate_en))
    else $error("reverse assembly not limited to binary reads");
  AST_LINK: assert property (@(posedge clk) disable iff (sys_rst)
    linked == (strobe_word[tape_ctl_pkg::CODE_LSB +: tape_ctl_pkg::CODE_W] ==
      (tape_ctl_pkg::CONNECT_CODE_0 | {3'b000, adapter_sel})))
    else $error("link does not follow own connect code");
  AST_CTRL_FLAG: assert property (@(posedge clk) disable iff (sys_rst)
    fire_ctrl && !clear_w |=> ctrl_is_connect == $past(ctl_word[tape_ctl_pkg::CONNECT_FLAG]))
    else $error("connect or function flag not taken");
  AST_CLEAR_ALL: assert property (@(posedge clk) disable iff (sys_rst)
    clear_w |=> ctrl_code == 12'h000 && !ctrl_is_connect && table_addr == 15'h0000 &&
      !compare_on_write)
    else $error("program clear left a latched word");
  AST_UNLINKED_STATUS: assert property (@(posedge clk) disable iff (sys_rst)
    !link_w |=> status_word == tape_ctl_pkg::WORD_RESET)
    else $error("status returned while unlinked");
endmodule

// ==== verif/scp_model.sv ====
// Station control processor model driving normal output channels 5 and 6.
`timescale 1ns/100ps
module scp_model (
  // Clock
  input wire logic clk,
  // Output channels 5 and 6
  output logic [15:0] ctl_word,
  output logic [15:0] strobe_word
);
  initial begin
    ctl_word = 16'h0000;
    strobe_word = 16'h0000;
  end

  // ********************************************************
  // Channel 6 levels and class strobes
  // ********************************************************
  // Puts a connect code and any held level bits on channel 6.
  task automatic set_level(input logic [3:0] code, input logic [15:0] lvl);
    @(negedge clk);
    strobe_word = lvl | {12'h000, code};
  endtask

  // Set-then-clear one class strobe while its word stands on channel 5.
  task automatic pulse(input int bitpos, input logic [15:0] word);
    @(negedge clk);
    ctl_word = word;
    strobe_word[bitpos] = 1'b1;
    @(negedge clk);
    strobe_word[bitpos] = 1'b0;
    @(negedge clk);
    @(negedge clk);
    // The word is no longer held, so show something that cannot pass for it.
    ctl_word = ~word;
  endtask

  // Sends an address in ones complement form with the top flag bit.
  task automatic load_addr(input int bitpos, input logic flag, input logic [14:0] a);
    pulse(bitpos, {flag, ~a});
  endtask
endmodule

// ==== verif/tb.sv ====
// Self-checking testbench for the tape channel control port.
`timescale 1ns/100ps
module tb;
  logic clk, sys_rst, adapter_sel, linked, compare_on_write, xlate_en, write_op;
  logic binary_mode, odd_even_banks, mem_inhibit, halt_on_error, read_reverse;
  logic reverse_assembly, start_pulse, program_clear, ctrl_is_connect, ctrl_send;
  logic [15:0] ctl_word, strobe_word, status_word, default_status;
  logic [14:0] current_addr, start_addr, table_addr;
  logic [10:0] term_offset;
  logic [3:0] next_page;
  logic [11:0] ctrl_code;
  logic [6:0] fl [10] = '{7'h01, 7'h02, 7'h08, 7'h10, 7'h20, 7'h40, 7'h41, 7'h7d, 7'h42, 7'h02};
  int bad_count, checks_done;

  scp_model i_scp_model (.clk, .ctl_word, .strobe_word);
  tape_channel_control_port i_tape_channel_control_port (.clk, .sys_rst, .adapter_sel,
    .ctl_word, .strobe_word, .status_word, .linked, .current_addr, .default_status,
    .start_addr, .term_offset, .next_page, .compare_on_write, .table_addr, .xlate_en,
    .write_op, .binary_mode, .odd_even_banks, .mem_inhibit, .halt_on_error, .read_reverse,
    .reverse_assembly, .start_pulse, .program_clear, .ctrl_code, .ctrl_is_connect,
    .ctrl_send);

  // ********************************************************
  // Helpers
  // ********************************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic results();
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Function bit n travels on channel bit n, which is vector bit 15-n.
  task automatic load_func(input logic [6:0] f);
    logic [15:0] w;
    w = 16'h0000;
    for (int n = 0; n < 7; n++) begin
      w[15 - n] = f[n];
    end
    i_scp_model.pulse(tape_ctl_pkg::STB_IFUNC, w);
  endtask

  task automatic fcheck(input logic [6:0] f, input logic sp);
    logic rr;
    rr = f[6] & ~f[1];
    chk({xlate_en, binary_mode, write_op, odd_even_banks, mem_inhibit, halt_on_error,
      read_reverse, reverse_assembly}, {f[0], ~f[0], f[1], f[3], f[4], f[5], rr,
      rr & ~f[0]}, "function bits");
    chk(start_pulse, sp, "start pulse");
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    results();
  end

  // ********************************************************
  // Tests
  // ********************************************************
  initial begin
    sys_rst = 1'b1;
    adapter_sel = 1'b0;
    current_addr = 15'h1234;
    default_status = 16'hbeef;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    chk({start_addr, binary_mode, linked, status_word}, {15'h0000, 1'b1, 1'b0, 16'h0000},
      "reset");
    i_scp_model.set_level(4'hc, 16'h0000);
    @(negedge clk);
    chk({linked, status_word}, {1'b1, 16'hbeef}, "default status");
    i_scp_model.load_addr(tape_ctl_pkg::STB_START, 1'b1, 15'h2b6d);
    @(negedge clk);
    chk(start_addr, 15'h2b6d, "start addr");
    i_scp_model.load_addr(tape_ctl_pkg::STB_TERM, 1'b1, 15'h4c3a);
    @(negedge clk);
    chk({next_page, term_offset, compare_on_write}, {4'h9, 11'h43a, 1'b0}, "term");
    i_scp_model.pulse(tape_ctl_pkg::STB_TABLE, {1'b0, ~7'h5b, 8'h5a});
    @(negedge clk);
    chk(table_addr, {7'h5b, 8'h00}, "table addr");
    for (int i = 0; i < 10; i++) begin
      load_func(fl[i]);
      fcheck(fl[i], 1'b1);
    end
    chk(compare_on_write, 1'b1, "compare on write");
    i_scp_model.load_addr(tape_ctl_pkg::STB_START, 1'b0, 15'h7001);
    @(negedge clk);
    fcheck(7'h02, 1'b0);
    for (int c = 1; c >= 0; c--) begin
      i_scp_model.pulse(tape_ctl_pkg::STB_CTRL, {2'b00, c[0], 1'b0, 12'ha5c ^ {12{c[0]}}});
      chk({ctrl_is_connect, ctrl_code, ctrl_send}, {c[0], 12'ha5c ^ {12{c[0]}}, 1'b1},
        "ctrl code");
    end
    i_scp_model.set_level(4'hc, 16'h0200);
    @(negedge clk);
    chk(status_word, {1'b0, current_addr}, "current addr");
    i_scp_model.set_level(4'hc, 16'h0000);
    @(negedge clk);
    chk(status_word, 16'hbeef, "status back");
    i_scp_model.set_level(4'h5, 16'h0000);
    i_scp_model.load_addr(tape_ctl_pkg::STB_START, 1'b0, 15'h0f0f);
    @(negedge clk);
    chk({linked, status_word, start_addr}, {1'b0, 16'h0000, 15'h7001}, "unlinked");
    adapter_sel = 1'b1;
    i_scp_model.set_level(4'hc, 16'h0000);
    i_scp_model.load_addr(tape_ctl_pkg::STB_START, 1'b0, 15'h0f0f);
    @(negedge clk);
    chk({linked, start_addr}, {1'b0, 15'h7001}, "other code");
    i_scp_model.set_level(4'hd, 16'h0000);
    i_scp_model.load_addr(tape_ctl_pkg::STB_START, 1'b0, 15'h0f0f);
    @(negedge clk);
    chk({linked, start_addr}, {1'b1, 15'h0f0f}, "own code");
    i_scp_model.set_level(4'hd, 16'h1000);
    #1 chk(program_clear, 1'b1, "clear level");
    @(negedge clk);
    chk({start_addr, binary_mode, write_op, table_addr, term_offset, next_page, ctrl_code,
      ctrl_is_connect}, {15'h0000, 1'b1, 1'b0, 15'h0000, 11'h000, 4'h0, 12'h000, 1'b0},
      "cleared");
    i_scp_model.set_level(4'hd, 16'h0000);
    @(negedge clk);
    results();
  end
endmodule
